/* File: logic/fpfma_pkg.sv */
package fpfma_pkg;

   // Instruction encodings
   localparam logic [5:0]  OPC_FPU     = 6'h11;
   localparam logic [5:0]  OPC_FPUX    = 6'h13;
   localparam logic [5:0]  FN_FMADD    = 6'h18;
   localparam logic [5:0]  FN_FMSUB    = 6'h19;
   localparam logic [2:0]  FN_LEG_MAC  = 3'h4;
   localparam logic [4:0]  FMT_S       = 5'h10;
   localparam logic [4:0]  FMT_D       = 5'h11;
   localparam logic [2:0]  FMT3_S      = 3'h0;
   localparam logic [2:0]  FMT3_D      = 3'h1;

   // Register offsets, control/status layout and reset values
   localparam logic [3:0]  REG_CTRL    = 4'h0;
   localparam logic [3:0]  REG_ISTAT   = 4'h4;
   localparam logic [3:0]  REG_IMASK   = 4'h8;
   localparam int          RM_LSB      = 0;
   localparam int          FLAG_LSB    = 2;
   localparam int          EN_LSB      = 7;
   localparam int          CAUSE_LSB   = 12;
   localparam int          FLUSH_BIT   = 24;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK  = 32'h0103_FFFF;
   localparam logic [3:0]  IRQ_RST     = 4'h0;
   localparam logic [1:0]  RM_NEAR     = 2'h0;
   localparam logic [1:0]  RM_ZERO     = 2'h1;
   localparam logic [1:0]  RM_PINF     = 2'h2;
   localparam logic [1:0]  RM_NINF     = 2'h3;
   localparam logic [1:0]  COP_UNIT    = 2'h1;

   // Number formats
   localparam int          PREC_D      = 53;
   localparam int          PREC_S      = 24;
   localparam int          BIAS_D      = 1023;
   localparam int          BIAS_S      = 127;
   localparam int          EMIN_D      = -1022;
   localparam int          EMIN_S      = -126;
   localparam logic [10:0] EINF_D      = 11'h7FF;
   localparam logic [10:0] EINF_S      = 11'h0FF;
   localparam logic [51:0] FRAC_ONES   = 52'hF_FFFF_FFFF_FFFF;
   localparam logic [63:0] QNAN_D      = 64'h7FF8_0000_0000_0000;
   localparam logic [63:0] QNAN_S      = 64'h0000_0000_7FC0_0000;
   localparam logic [63:0] ONE_D       = 64'h3FF0_0000_0000_0000;
   localparam logic [63:0] ONE_S       = 64'h0000_0000_3F80_0000;
   localparam logic [63:0] NZERO_D     = 64'h8000_0000_0000_0000;
   localparam logic [63:0] NZERO_S     = 64'h0000_0000_8000_0000;
   localparam int          FW          = 218;
   localparam int          TOP         = 214;
   localparam int          ZERO_EXP    = -4000;

   typedef enum logic [1:0] {OP_NONE = 2'b00, OP_FMA = 2'b01, OP_FMS = 2'b10, OP_LEG = 2'b11} fpfma_op_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_PROD = 2'b01, ST_SUM = 2'b10} fpfma_state_t;
   typedef enum logic [1:0] {EXC_NONE = 2'b00, EXC_CPU = 2'b01, EXC_RI = 2'b10, EXC_FPE = 2'b11} fpfma_exc_t;
   typedef struct packed {fpfma_op_t op; logic fmt_ok; logic dbl;} fpfma_dec_t;
   typedef struct packed {logic sgn; logic signed [12:0] exp; logic [52:0] sig;
                          logic zero; logic inf; logic nan; logic snan; logic fl;} fpfma_val_t;
   typedef struct packed {logic e; logic v; logic z; logic o; logic u; logic i;} fpfma_cause_t;
   typedef struct packed {logic [63:0] res; fpfma_cause_t cause;} fpfma_res_t;

endpackage

/* File: logic/fpfma_core.sv */
// Functional notes
// - Decode fused add from coprocessor opcode, function.
// - Decode fused subtract by its function code.
// - Fused forms keep product exact before accumulation.
// - Fused forms take old destination value as the addend.
// - Fused forms: one rounding with current rounding mode.
// - Subtract gives destination minus product.
// - Cause ORed into flags when no trap.
// - Disabled unit raises coprocessor-unusable, no write.
// - Unimplemented format raises reserved instruction.
// - Inexact/overflow/underflow from rounding; legacy form also keeps product-pass flags.
// - Flush mode zeroes subnormal inputs, signals inexact.
// - Inexact is flush inexact OR arithmetic inexact.
// - Five conditions reported as cause, trap if enabled.
// - Legacy form rounds product, then adds addend.
`timescale 1ns/1ps
`default_nettype none

module fpfma_core
   import fpfma_pkg::*;
(
   input  wire logic        CLK_IN,         // Core clock, 40 MHz
   input  wire logic        RST_IN,         // Synchronous reset, high
   input  wire logic        ISSUE_VALID_IN, // Instruction offered this cycle
   input  wire logic [31:0] ISSUE_INSTR_IN, // Instruction word
   input  wire logic        FPU_ENABLE_IN,  // Floating-point unit usable
   input  wire logic [63:0] ACCUM_VAL_IN,   // Old dest_accum register value
   input  wire logic [63:0] SRC_A_VAL_IN,   // src_a register value
   input  wire logic [63:0] SRC_B_VAL_IN,   // src_b register value
   input  wire logic [63:0] ADDEND_VAL_IN,  // addend register value
   input  wire logic [3:0]  REG_ADDR_IN,    // Register byte address
   input  wire logic [31:0] REG_WDATA_IN,   // Register write data
   input  wire logic        REG_WR_IN,      // Register write strobe
   input  wire logic        REG_RD_IN,      // Register read strobe
   output logic             BUSY_OUT,       // Operation in flight
   output logic             WB_VALID_OUT,   // Result write-back pulse
   output logic [4:0]       WB_REG_OUT,     // Destination register number
   output logic [63:0]      WB_DATA_OUT,    // Result value
   output logic             EXC_VALID_OUT,  // Exception pulse
   output fpfma_exc_t       EXC_CODE_OUT,   // Exception kind
   output logic [1:0]       EXC_COP_OUT,    // Coprocessor number
   output logic [31:0]      REG_RDATA_OUT,  // Read data, cycle after strobe
   output logic             IRQ_OUT         // Level interrupt
);

   fpfma_state_t state, next_state;
   logic [63:0]  a, b, c, addend, next_a, next_b, next_c, next_addend;
   logic [4:0]   dst, next_dst;
   logic         dbl, neg, next_dbl, next_neg, next_busy, next_wb_valid, next_exc_valid;
   logic [63:0]  next_wb_data;
   fpfma_exc_t   next_exc_code;
   logic [1:0]   next_exc_cop;
   fpfma_cause_t acc, next_acc, all;
   fpfma_dec_t   dec;
   fpfma_val_t   ua, ub, uc;
   fpfma_res_t   fres;
   logic         take, trap, fin, ev_cpu, ev_ri;
   logic [31:0]  csr, next_csr, next_rdata;
   logic [3:0]   istat, imask, next_istat, next_imask, clr;
   logic         next_irq;

   // Packs sign, biased exponent and left-aligned fraction into the format
   function automatic logic [63:0] pack(input logic s, input logic [10:0] be, input logic [51:0] f,
                                        input logic d);
      return d ? {s, be, f} : {32'h0000_0000, s, be[7:0], f[51:29]};
   endfunction

   function automatic fpfma_dec_t decode(input logic [31:0] w);
      fpfma_dec_t r;
      r = '{op: OP_NONE, fmt_ok: 1'b0, dbl: 1'b0};
      if (w[31:26] == OPC_FPU && w[5:0] == FN_FMADD) begin
         r.op = OP_FMA;
      end
      if (w[31:26] == OPC_FPU && w[5:0] == FN_FMSUB) begin
         r.op = OP_FMS;
      end
      if (w[31:26] == OPC_FPUX && w[5:3] == FN_LEG_MAC) begin
         r.op = OP_LEG;
      end
      if (r.op == OP_LEG) begin
         r.dbl    = w[2:0] == FMT3_D;
         r.fmt_ok = w[2:0] == FMT3_S || w[2:0] == FMT3_D;
      end else begin
         r.dbl    = w[25:21] == FMT_D;
         r.fmt_ok = w[25:21] == FMT_S || w[25:21] == FMT_D;
      end
      return r;
   endfunction

   // Unpacks to a common 53-bit significand; single sits at the top bits
   function automatic fpfma_val_t unpack(input logic [63:0] x, input logic d, input logic flush);
      fpfma_val_t v;
      logic [10:0] e;
      logic [51:0] f;
      e      = d ? x[62:52] : {3'h0, x[30:23]};
      f      = d ? x[51:0] : {x[22:0], 29'h0};
      v.sgn  = d ? x[63] : x[31];
      v.inf  = e == (d ? EINF_D : EINF_S) && f == '0;
      v.nan  = e == (d ? EINF_D : EINF_S) && f != '0;
      v.snan = v.nan && !f[51];
      v.fl   = flush && e == '0 && f != '0;
      v.zero = e == '0 && (f == '0 || flush);
      v.sig  = v.zero ? '0 : {e != '0, f};
      v.exp  = v.zero ? 13'(ZERO_EXP) : 13'((e == '0 ? 1 : int'(e)) - (d ? BIAS_D : BIAS_S));
      return v;
   endfunction

   function automatic int lead(input logic [FW-1:0] v);
      int n;
      n = 0;
      for (int i = 0; i < FW; i++) begin
         if (v[i]) begin
            n = i;
         end
      end
      return n;
   endfunction

   // Exact a*b + c in a wide frame, then a single rounding to the format
   function automatic fpfma_res_t fuse(input fpfma_val_t x, input fpfma_val_t y, input fpfma_val_t z,
                                       input logic d, input logic [1:0] rm);
      fpfma_res_t  r;
      logic        sp, ss, bp, rbit, stk, tiny, inc;
      logic [105:0] prod;
      logic [FW-1:0] big, sml, s;
      logic [2*FW-1:0] w;
      logic [53:0] kept;
      int          ep, ec, em, e, q, k, p, dd, emn, bias;
      r    = '0;
      p    = d ? PREC_D : PREC_S;
      emn  = d ? EMIN_D : EMIN_S;
      bias = d ? BIAS_D : BIAS_S;
      sp   = x.sgn ^ y.sgn;
      prod = x.sig * y.sig;
      ep   = (x.zero || y.zero) ? ZERO_EXP : int'(x.exp) + int'(y.exp);
      ec   = int'(z.exp);
      if (x.nan || y.nan || z.nan || (x.inf && y.zero) || (x.zero && y.inf) ||
          ((x.inf || y.inf) && z.inf && sp != z.sgn)) begin
         r.cause.v = x.snan | y.snan | z.snan | !(x.nan | y.nan | z.nan);
         r.res     = d ? QNAN_D : QNAN_S;
      end else if (x.inf || y.inf || z.inf) begin
         r.res = pack((x.inf || y.inf) ? sp : z.sgn, d ? EINF_D : EINF_S, '0, d);
      end else begin
         bp   = ep >= ec;
         em   = bp ? ep : ec;
         big  = bp ? {2'b00, prod, 110'h0} : {3'b000, z.sig, 162'h0};
         sml  = bp ? {3'b000, z.sig, 162'h0} : {2'b00, prod, 110'h0};
         dd   = bp ? ep - ec : ec - ep;
         w    = {sml, {FW{1'b0}}} >> (dd > FW ? FW : dd);
         sml  = w[2*FW-1:FW] | FW'(|w[FW-1:0]);
         ss   = bp ? sp : z.sgn;
         if (sp == z.sgn) begin
            s = big + sml;
         end else if (big >= sml) begin
            s = big - sml;
         end else begin
            s  = sml - big;
            ss = !ss;
         end
         if (s == '0) begin
            r.res = pack((sp == z.sgn) ? sp : (rm == RM_NINF), '0, '0, d);
         end else begin
            e    = em + lead(s) - TOP;
            tiny = e < emn;
            q    = (tiny ? emn : e) - p + 1;
            k    = q - (em - TOP);
            rbit = 1'b0;
            stk  = 1'b0;
            if (k <= 0) begin
               w    = {{FW{1'b0}}, s} << (-k);
               kept = w[53:0];
            end else if (k > FW) begin
               kept = '0;
               stk  = 1'b1;
            end else begin
               w    = {s, {FW{1'b0}}} >> k;
               kept = w[FW+53:FW];
               rbit = w[FW-1];
               stk  = |w[FW-2:0];
            end
            unique case (rm)
               RM_NEAR: inc = rbit && (stk || kept[0]);
               RM_ZERO: inc = 1'b0;
               RM_PINF: inc = !ss && (rbit || stk);
               RM_NINF: inc = ss && (rbit || stk);
            endcase
            kept = kept + 54'(inc);
            if (kept[p]) begin
               kept = kept >> 1;
               q    = q + 1;
            end
            r.cause.i = rbit | stk;
            r.cause.u = tiny && (rbit | stk);
            w     = {{FW{1'b0}}, 164'h0, kept} << (53 - p);
            r.res = pack(ss, kept[p-1] ? 11'(q + p - 1 + bias) : 11'h000, w[51:0], d);
            if (kept[p-1] && q + p - 1 > bias) begin
               r.cause.o = 1'b1;
               r.cause.i = 1'b1;
               if (rm == RM_ZERO || (rm == RM_PINF && ss) || (rm == RM_NINF && !ss)) begin
                  r.res = pack(ss, (d ? EINF_D : EINF_S) - 11'h001, FRAC_ONES, d);
               end else begin
                  r.res = pack(ss, d ? EINF_D : EINF_S, '0, d);
               end
            end
         end
      end
      return r;
   endfunction

   // Sequencer and datapath; the shared rounding unit serves both legacy passes
   always_comb begin
      dec  = decode(ISSUE_INSTR_IN);
      ua   = unpack(a, dbl, csr[FLUSH_BIT]);
      ub   = unpack(b, dbl, csr[FLUSH_BIT]);
      uc   = unpack(c, dbl, csr[FLUSH_BIT]);
      ua.sgn = ua.sgn ^ neg;
      fres = fuse(ua, ub, uc, dbl, csr[RM_LSB+:2]);
      fres.cause.i = fres.cause.i | ua.fl | ub.fl | uc.fl;
      all  = fres.cause | acc;
      trap = all.e || (all[4:0] & csr[EN_LSB+:5]) != '0;
      fin  = state == ST_SUM;
      take = state == ST_IDLE && ISSUE_VALID_IN && dec.op != OP_NONE && FPU_ENABLE_IN && dec.fmt_ok;
      ev_cpu = state == ST_IDLE && ISSUE_VALID_IN && dec.op != OP_NONE && !FPU_ENABLE_IN;
      ev_ri  = state == ST_IDLE && ISSUE_VALID_IN && dec.op != OP_NONE && FPU_ENABLE_IN && !dec.fmt_ok;
      next_state = state;
      next_a = a;
      next_b = b;
      next_c = c;
      next_addend = addend;
      next_dst = dst;
      next_dbl = dbl;
      next_neg = neg;
      next_acc = acc;
      next_wb_valid = 1'b0;
      next_wb_data = WB_DATA_OUT;
      next_exc_valid = ev_cpu | ev_ri;
      next_exc_code = ev_cpu ? EXC_CPU : (ev_ri ? EXC_RI : EXC_NONE);
      next_exc_cop = ev_cpu ? COP_UNIT : 2'h0;
      unique case (state)
         ST_IDLE: begin
            if (take) begin
               next_a = SRC_A_VAL_IN;
               next_b = SRC_B_VAL_IN;
               next_c = (dec.op == OP_LEG) ? (dec.dbl ? NZERO_D : NZERO_S) : ACCUM_VAL_IN;
               next_addend = ADDEND_VAL_IN;
               next_neg = dec.op == OP_FMS;
               next_dst = ISSUE_INSTR_IN[10:6];
               next_dbl = dec.dbl;
               next_acc = '0;
               next_state = (dec.op == OP_LEG) ? ST_PROD : ST_SUM;
            end
         end
         ST_PROD: begin
            // First legacy pass rounds the product; flags carry into the add
            next_a = fres.res;
            next_b = dbl ? ONE_D : ONE_S;
            next_c = addend;
            next_neg = 1'b0;
            next_acc = fres.cause;
            next_state = ST_SUM;
         end
         ST_SUM: begin
            next_state = ST_IDLE;
            if (trap) begin
               next_exc_valid = 1'b1;
               next_exc_code = EXC_FPE;
            end else begin
               next_wb_valid = 1'b1;
               next_wb_data = fres.res;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      next_busy = next_state != ST_IDLE;
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         state <= ST_IDLE;
         a <= '0;
         b <= '0;
         c <= '0;
         addend <= '0;
         dst <= '0;
         dbl <= 1'b0;
         neg <= 1'b0;
         acc <= '0;
         BUSY_OUT <= 1'b0;
         WB_VALID_OUT <= 1'b0;
         WB_REG_OUT <= '0;
         WB_DATA_OUT <= '0;
         EXC_VALID_OUT <= 1'b0;
         EXC_CODE_OUT <= EXC_NONE;
         EXC_COP_OUT <= 2'h0;
      end else begin
         state <= next_state;
         a <= next_a;
         b <= next_b;
         c <= next_c;
         addend <= next_addend;
         dst <= next_dst;
         dbl <= next_dbl;
         neg <= next_neg;
         acc <= next_acc;
         BUSY_OUT <= next_busy;
         WB_VALID_OUT <= next_wb_valid;
         WB_REG_OUT <= next_dst;
         WB_DATA_OUT <= next_wb_data;
         EXC_VALID_OUT <= next_exc_valid;
         EXC_CODE_OUT <= next_exc_code;
         EXC_COP_OUT <= next_exc_cop;
      end
   end

   // Register file; completion beats a same-cycle software write to cause and ORs into the flags it wrote
   always_comb begin
      next_csr = csr;
      if (REG_WR_IN && REG_ADDR_IN == REG_CTRL) begin
         next_csr = REG_WDATA_IN & CTRL_WMASK;
      end
      if (fin) begin
         next_csr[CAUSE_LSB+:6] = all;
         if (!trap) begin
            next_csr[FLAG_LSB+:5] = next_csr[FLAG_LSB+:5] | all[4:0];
         end
      end
      clr = (REG_WR_IN && REG_ADDR_IN == REG_ISTAT) ? REG_WDATA_IN[3:0] : 4'h0;
      next_istat = (istat & ~clr) | {fin && trap, ev_ri, ev_cpu, fin && !trap};
      next_imask = (REG_WR_IN && REG_ADDR_IN == REG_IMASK) ? REG_WDATA_IN[3:0] : imask;
      next_irq = |(next_istat & next_imask);
      next_rdata = 32'h0000_0000;
      if (REG_RD_IN) begin
         unique case (REG_ADDR_IN)
            REG_CTRL:  next_rdata = csr;
            REG_ISTAT: next_rdata = {28'h000_0000, istat};
            REG_IMASK: next_rdata = {28'h000_0000, imask};
            default:   next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         csr <= CTRL_RST;
         istat <= IRQ_RST;
         imask <= IRQ_RST;
         REG_RDATA_OUT <= '0;
         IRQ_OUT <= 1'b0;
      end else begin
         csr <= next_csr;
         istat <= next_istat;
         imask <= next_imask;
         REG_RDATA_OUT <= next_rdata;
         IRQ_OUT <= next_irq;
      end
   end

   // Checks
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   a_fused_issue: assert property ((take && dec.op == OP_FMA) |=>
      (state == ST_SUM && !neg) ##1 (WB_VALID_OUT || EXC_VALID_OUT)) else $error("fused add not done in two cycles");
   a_msub_negate: assert property ((take && dec.op == OP_FMS) |=> neg && state == ST_SUM)
      else $error("fused subtract did not negate product");
   a_accum_operand: assert property (take && dec.op != OP_LEG |=> c == $past(ACCUM_VAL_IN))
      else $error("old destination not captured as addend");
   a_legacy_passes: assert property ((take && dec.op == OP_LEG) |=> state == ST_PROD
      ##1 state == ST_SUM ##1 (WB_VALID_OUT || EXC_VALID_OUT)) else $error("legacy form not two passes");
   a_cop_unusable: assert property (ev_cpu |=> EXC_VALID_OUT && EXC_CODE_OUT == EXC_CPU
      && EXC_COP_OUT == COP_UNIT && !WB_VALID_OUT) else $error("disabled unit not trapped");
   a_bad_format: assert property (ev_ri |=> EXC_VALID_OUT && EXC_CODE_OUT == EXC_RI && state == ST_IDLE)
      else $error("bad format not reserved");
   a_flags_sticky: assert property (WB_VALID_OUT |->
      (csr[FLAG_LSB+:5] & csr[CAUSE_LSB+:5]) == csr[CAUSE_LSB+:5]) else $error("cause not in flags");
   a_trap_no_flags: assert property ((EXC_VALID_OUT && EXC_CODE_OUT == EXC_FPE && !$past(REG_WR_IN))
      |-> csr[FLAG_LSB+:5] == $past(csr[FLAG_LSB+:5]) && !WB_VALID_OUT) else $error("trap changed flags");
   a_flush_inexact: assert property ((fin && (ua.fl || ub.fl || uc.fl)) |=> csr[CAUSE_LSB])
      else $error("flushed input missed inexact");
   a_exact_clean: assert property ((fin && !fres.cause.i) |-> !fres.cause.o && !fres.cause.u)
      else $error("exact result flagged");

   c_fused_wb: cover property (take ##2 WB_VALID_OUT);
   c_legacy_wb: cover property ((take && dec.op == OP_LEG) ##3 WB_VALID_OUT);
   c_fp_trap: cover property (EXC_VALID_OUT && EXC_CODE_OUT == EXC_FPE);
   c_irq: cover property (IRQ_OUT);

endmodule

`default_nettype wire

/* File: testbench/fpfma_issue_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Issue-side register file: operands follow the offered word, results land on write-back
module fpfma_issue_model (
   input  wire logic        CLK_IN,      // Core clock
   input  wire logic [31:0] INSTR_IN,    // Offered word
   input  wire logic        WB_VALID_IN, // Write-back pulse
   input  wire logic [4:0]  WB_REG_IN,   // Write-back target
   input  wire logic [63:0] WB_DATA_IN,  // Write-back value
   output logic      [63:0] ACCUM_OUT,   // Destination as a source
   output logic      [63:0] SRC_A_OUT,   // First factor
   output logic      [63:0] SRC_B_OUT,   // Second factor
   output logic      [63:0] ADDEND_OUT   // Legacy addend
);
   logic [63:0] fpr [32];
   // Destination is read before its write-back, so it counts as a source
   assign ACCUM_OUT  = fpr[INSTR_IN[10:6]];
   assign SRC_A_OUT  = fpr[INSTR_IN[15:11]];
   assign SRC_B_OUT  = fpr[INSTR_IN[20:16]];
   assign ADDEND_OUT = fpr[INSTR_IN[25:21]];
   // Results go back to the file, as the pipeline would forward them
   always @(posedge CLK_IN) begin
      if (WB_VALID_IN) fpr[WB_REG_IN] <= WB_DATA_IN;
   end
   task automatic load(input logic [4:0] r, input logic [63:0] v);
      fpr[r] = v;
   endtask
endmodule
`default_nettype wire

/* File: testbench/fp_fused_multiply_add_test.sv */
`timescale 1ns/1ps
`default_nettype none
module fp_fused_multiply_add_test;
   import fpfma_pkg::*;
   logic clk = 0, rst = 1, iv = 0, cen = 1, wr = 0, rd = 0, busy, wbv, excv, irq, rd_cur = 0;
   logic [31:0] instr = 0, wd = 0, rdat;
   logic [3:0] ad = 0;
   logic [63:0] acc, sa, sb, adn, wdat;
   logic [4:0] wreg;
   fpfma_exc_t ecode;
   logic [1:0] ecop;
   logic [16:0] lf = 17'h14AB7;
   logic [68:0] q_wb[$];
   logic [3:0] q_exc[$];
   logic [31:0] q_rd[$];
   int miscompares = 0, checks = 0;
   localparam logic [63:0] TWO = 64'h4000_0000_0000_0000, THR = 64'h4008_0000_0000_0000;
   localparam logic [63:0] ULP1 = 64'h3FF0_0000_0000_0001;

   fpfma_core u_fpfma_core (.CLK_IN(clk), .RST_IN(rst), .ISSUE_VALID_IN(iv), .ISSUE_INSTR_IN(instr),
      .FPU_ENABLE_IN(cen), .ACCUM_VAL_IN(acc), .SRC_A_VAL_IN(sa), .SRC_B_VAL_IN(sb), .ADDEND_VAL_IN(adn),
      .REG_ADDR_IN(ad), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .BUSY_OUT(busy),
      .WB_VALID_OUT(wbv), .WB_REG_OUT(wreg), .WB_DATA_OUT(wdat), .EXC_VALID_OUT(excv),
      .EXC_CODE_OUT(ecode), .EXC_COP_OUT(ecop), .REG_RDATA_OUT(rdat), .IRQ_OUT(irq));
   fpfma_issue_model u_fpfma_issue_model (.CLK_IN(clk), .INSTR_IN(instr), .WB_VALID_IN(wbv),
      .WB_REG_IN(wreg), .WB_DATA_IN(wdat), .ACCUM_OUT(acc), .SRC_A_OUT(sa), .SRC_B_OUT(sb), .ADDEND_OUT(adn));

   // 40 MHz core clock
   always #12.5 clk = ~clk;

   task automatic rep(input logic [68:0] g, input logic [68:0] e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cmp_wb(input logic [68:0] g, input logic [68:0] e); rep(g, e); endtask
   task automatic cmp_exc(input logic [3:0] g, input logic [3:0] e); rep({65'h0, g}, {65'h0, e}); endtask
   task automatic cmp_val(input logic [31:0] g, input logic [31:0] e); rep({37'h0, g}, {37'h0, e}); endtask

   task automatic finish_test;
      // Results that never arrived count against the run
      miscompares += q_wb.size() + q_exc.size() + q_rd.size();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Register port: one-cycle strobes driven just after the edge
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1; ad <= a; wd <= d;
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
      q_rd.push_back(e);
      @(posedge clk);
      rd <= 1; ad <= a;
      @(posedge clk);
      rd <= 0;
   endtask

   // Random destination from the shift register; sources sit above it, all below the legacy addend 31
   function automatic logic [31:0] word(input logic [5:0] opc, input logic [4:0] f5, input logic [5:0] lo);
      lf = {lf[15:0], lf[16] ^ lf[13]};
      return {opc, f5, {1'b0, lf[3:0]} + 5'h2, {1'b0, lf[3:0]} + 5'h1, {1'b0, lf[3:0]}, lo};
   endfunction

   // kind 0: write-back expected; otherwise the exception code and unit
   task automatic fma(input logic [31:0] w, input logic [63:0] d, a, b, r, ev, input logic [3:0] ex);
      u_fpfma_issue_model.load(w[25:21], r);
      u_fpfma_issue_model.load(w[20:16], b);
      u_fpfma_issue_model.load(w[15:11], a);
      u_fpfma_issue_model.load(w[10:6], d);
      if (ex == 4'h0) q_wb.push_back({w[10:6], ev});
      else q_exc.push_back(ex);
      @(posedge clk);
      iv <= 1; instr <= w;
      @(posedge clk);
      iv <= 0;
      #1 cmp_val({31'h0, busy}, {31'h0, ex == 4'h0 || ex == 4'hC});
      repeat (4) @(posedge clk);
   endtask

   // Result watcher: every result pops the oldest note
   always @(posedge clk) begin
      rd_cur = rd;
      #1;
      if (wbv === 1'b1) cmp_wb({wreg, wdat}, (q_wb.size() > 0) ? q_wb.pop_front() : 69'h0);
      if (excv === 1'b1) cmp_exc({ecode, ecop}, (q_exc.size() > 0) ? q_exc.pop_front() : 4'hF);
      if (rd_cur) cmp_val(rdat, (q_rd.size() > 0) ? q_rd.pop_front() : 32'hFFFF_FFFF);
   end

   // Watchdog sized well above the whole sequence
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      finish_test();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      reg_wr(REG_IMASK, 32'h0000_0001);
      fma(word(OPC_FPU, FMT_D, FN_FMADD), ONE_D, TWO, THR, 0, 64'h401C_0000_0000_0000, 0);
      cmp_val({31'h0, irq}, 32'h1);
      reg_wr(REG_ISTAT, 32'h0000_0001);
      repeat (2) @(posedge clk);
      #1 cmp_val({31'h0, irq}, 32'h0);
      fma(word(OPC_FPU, FMT_D, FN_FMSUB), ONE_D, TWO, THR, 0, 64'hC014_0000_0000_0000, 0);
      fma(word(OPC_FPU, FMT_S, FN_FMADD), ONE_S, 64'h4000_0000, 64'h4040_0000, 0, 64'h40E0_0000, 0);
      fma(word(OPC_FPUX, 5'h1F, {FN_LEG_MAC, FMT3_D}), 0, TWO, THR, ONE_D, 64'h401C_0000_0000_0000, 0);
      fma(word(OPC_FPUX, 5'h1F, {FN_LEG_MAC, FMT3_S}),
          0, 64'h4000_0000, 64'h4040_0000, ONE_S, 64'h40E0_0000, 0);
      reg_rd(REG_CTRL, 32'h0000_0000);
      fma(word(OPC_FPU, FMT_D, FN_FMADD), ONE_D, ULP1, ULP1, 0, TWO + 64'h1, 0);
      reg_rd(REG_CTRL, 32'h0000_1004);
      reg_wr(REG_CTRL, {30'h0, RM_PINF});
      fma(word(OPC_FPU, FMT_D, FN_FMADD), ONE_D, ULP1, ULP1, 0, TWO + 64'h2, 0);
      reg_wr(REG_CTRL, {30'h0, RM_NINF});
      fma(word(OPC_FPU, FMT_D, FN_FMSUB), ONE_D, ULP1, ULP1, 0, 64'hBCC0_0000_0000_0001, 0);
      reg_wr(REG_CTRL, 32'h0000_0080);
      fma(word(OPC_FPU, FMT_D, FN_FMADD), ONE_D, ULP1, ULP1, 0, 0, {EXC_FPE, 2'h0});
      reg_rd(REG_CTRL, 32'h0000_1080);
      reg_wr(REG_CTRL, 32'h0100_0000);
      fma(word(OPC_FPU, FMT_D, FN_FMADD), 0, 64'h1, TWO, 0, 64'h0, 0);
      reg_rd(REG_CTRL, 32'h0100_1004);
      cen <= 0;
      fma(word(OPC_FPU, FMT_D, FN_FMADD), ONE_D, TWO, THR, 0, 0, {EXC_CPU, COP_UNIT});
      cen <= 1;
      fma(word(OPC_FPU, 5'h12, FN_FMSUB), ONE_D, TWO, THR, 0, 0, {EXC_RI, 2'h0});
      reg_wr(4'hC, {lf, 15'h0});
      reg_rd(4'hC, 32'h0000_0000);
      reg_rd(REG_ISTAT, 32'h0000_000F);
      repeat (3) @(posedge clk);
      finish_test();
   end
endmodule
`default_nettype wire
